// ===== kpi_pkg.sv
package kpi_pkg;
   // line counts: eight sense lines, ten drive lines, one flat vector
   localparam int KPI_NROW = 8;
   localparam int KPI_NCOL = 10;
   localparam int KPI_NL = 18;
   // seven-bit bus address of this device
   localparam logic [6:0] KPI_SLV_ADDR = 7'h34;
   // register pointer values
   localparam logic [7:0] KPI_A_CFG = 8'h01;
   localparam logic [7:0] KPI_A_IST1 = 8'h11;
   localparam logic [7:0] KPI_A_IST2 = 8'h12;
   localparam logic [7:0] KPI_A_IST3 = 8'h13;
   localparam logic [7:0] KPI_A_DAT1 = 8'h14;
   localparam logic [7:0] KPI_A_DAT2 = 8'h15;
   localparam logic [7:0] KPI_A_DAT3 = 8'h16;
   // configuration field positions and reset value
   localparam int KPI_CFG_AI = 7;
   localparam int KPI_CFG_INTP = 4;
   localparam logic [7:0] KPI_CFG_RST = 8'h00;
   // lines idle high through the pull-ups after reset
   localparam logic [17:0] KPI_LVL_RST = 18'h3FFFF;
   // interrupt release pulse, time and clock rate
   localparam int KPI_PULSE_US = 50;
   localparam int KPI_MCLK_MHZ = 10;
   localparam int KPI_PULSE_CYC = KPI_PULSE_US * KPI_MCLK_MHZ;
   // bus slave states
   typedef enum logic [2:0] {
      KPI_IDLE = 3'b000,
      KPI_ADDR = 3'b001,
      KPI_AACK = 3'b010,
      KPI_WBYTE = 3'b011,
      KPI_WACK = 3'b100,
      KPI_RBYTE = 3'b101,
      KPI_RACK = 3'b110,
      KPI_WAIT = 3'b111
   } kpi_state_e;
   // per-line configuration from the owning logic
   typedef struct packed {
      logic [17:0] is_out;  // line is an output
      logic [17:0] in_kp;   // line belongs to the keypad matrix
      logic [17:0] out_val; // level for output lines
   } kpi_line_cfg_s;
   // pad controls for all eighteen lines
   typedef struct packed {
      logic [17:0] o;
      logic [17:0] oe;
      logic [17:0] pu_en;
   } kpi_pad_s;
endpackage : kpi_pkg

// ===== kpi_host_port.sv
`timescale 1ns/100ps
// Contract
// - after reset all lines inputs, pull-ups on
// - sense lines: gpio input, keypad open-drain pulled
// - drive lines: gpio input, keypad open-drain output
// - reset pin forces registers and bus defaults
// - power-on reset acts like reset pin
// - any edge on an input raises interrupt
// - clear on level return or port read
// - read clear happens at acknowledge bit
// - changes after clear are flagged again
// - outputs and foreign traffic never touch interrupt
// - output-to-input switch may flag spuriously
// - pulse mode: clear with pending gives 50us gap
// - no pulse mode: interrupt stays asserted
// - interrupt is active-low open-drain
// - device acknowledges its address low
// - one bit per clock, change only while low
// - ack after each byte, transmitter releases
// - device acks every received byte
// - master nack ends read, device releases
// - address lsb one reads, zero writes
// - first written byte loads register pointer
module kpi_host_port (
   // main clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // free-running debounce clock
   input wire logic dbclk,
   // serial bus, open-drain data
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // keypad and gpio lines
   input wire logic [17:0] line_i,
   input wire kpi_pkg::kpi_line_cfg_s line_cfg,
   output kpi_pkg::kpi_pad_s pad,
   // open-drain interrupt, active low
   output logic int_n_o,
   output logic int_n_oe
);
   import kpi_pkg::*;

   // mask of one register port, from its read address
   function automatic logic [17:0] port_mask(input logic [7:0] a);
      case (a)
         KPI_A_IST1, KPI_A_DAT1: port_mask = 18'h000FF;
         KPI_A_IST2, KPI_A_DAT2: port_mask = 18'h0FF00;
         KPI_A_IST3, KPI_A_DAT3: port_mask = 18'h30000;
         default: port_mask = 18'h00000;
      endcase
   endfunction : port_mask

   // read data for a register address
   function automatic logic [7:0] rd_data(input logic [7:0] a, input logic [7:0] c,
                                          input logic [17:0] s, input logic [17:0] l);
      case (a)
         KPI_A_CFG: rd_data = c;
         KPI_A_IST1: rd_data = s[7:0];
         KPI_A_IST2: rd_data = s[15:8];
         KPI_A_IST3: rd_data = {6'h00, s[17:16]};
         KPI_A_DAT1: rd_data = l[7:0];
         KPI_A_DAT2: rd_data = l[15:8];
         KPI_A_DAT3: rd_data = {6'h00, l[17:16]};
         default: rd_data = 8'h00;
      endcase
   endfunction : rd_data

   // ---------------- debounce domain ----------------
   logic [1:0] db_rst_q;      // reset carried into the debounce domain
   logic [17:0] db_m_q;       // pin synchroniser, first stage
   logic [17:0] db_s_q;       // pin synchroniser, second stage
   logic [17:0] db_a_q;       // first debounce sample
   logic [17:0] db_b_q;       // confirmed level

   // reset crossing; power-on and pin reset share rst_n
   always_ff @(posedge dbclk) begin
      db_rst_q <= {db_rst_q[0], rst_n};
   end

   // pins are async to dbclk, so two flops before any compare
   always_ff @(posedge dbclk) begin
      db_m_q <= line_i;
      db_s_q <= db_m_q;
   end

   // a level is passed on only if two samples agree
   always_ff @(posedge dbclk) begin
      if (!db_rst_q[1]) begin
         db_a_q <= KPI_LVL_RST;
         db_b_q <= KPI_LVL_RST;
      end else begin
         db_a_q <= db_s_q;
         for (int i = 0; i < KPI_NL; i++) begin
            if (db_s_q[i] == db_a_q[i]) begin
               db_b_q[i] <= db_a_q[i];
            end
         end
      end
   end

   // ---------------- main domain ----------------
   logic [17:0] lx_m_q;       // level crossing, first stage
   logic [17:0] lvl_q;        // debounced level in mclk
   logic [17:0] lvl_p_q;      // level one cycle ago
   logic [17:0] ref_q;        // level at last clear
   logic [17:0] ist_q;        // per-line pending change
   logic [17:0] ist_d;
   logic [17:0] is_out_q;     // registered line config
   logic [17:0] in_kp_q;
   logic [17:0] out_val_q;
   logic [17:0] in_mask;      // lines that act as inputs
   logic [17:0] edge_v;       // debounced edges
   logic [7:0] cfg_q;         // configuration register
   logic [9:0] pls_q;         // release pulse timer
   logic int_q;               // interrupt asserted
   logic [2:0] scl_s_q;       // bus clock sync plus history
   logic [2:0] sda_s_q;       // bus data sync plus history
   logic scl_rise, scl_fall, bus_start, bus_stop;
   kpi_state_e st_q;          // bus state
   logic [3:0] cnt_q;         // bits in current byte
   logic [7:0] sh_q;          // receive shift register
   logic [7:0] tx_q;          // transmit shift register
   logic [7:0] ptr_q;         // register pointer
   logic [7:0] rda_q;         // address of byte being read
   logic ptr_ok_q;            // pointer byte already taken
   logic sda_oe_q;            // drive data low
   logic clr_stb;             // read clear at ack clock rise
   logic [7:0] nxt_ptr;
   logic [17:0] rd_mask;      // lines of the port being read
   logic [7:0] rd_byte;       // read data at the pointer

   // config is held inputs-with-pull-ups until reset releases
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         is_out_q <= 18'h00000;
         in_kp_q <= 18'h00000;
         out_val_q <= 18'h00000;
      end else begin
         is_out_q <= line_cfg.is_out;
         in_kp_q <= line_cfg.in_kp;
         out_val_q <= line_cfg.out_val;
      end
   end

   // keypad drive lines are outputs, everything else per config
   assign in_mask = ~is_out_q & ~(in_kp_q & {{KPI_NCOL{1'b1}}, {KPI_NROW{1'b0}}});

   // pad drivers per line structure
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pad.o <= 18'h00000;
         pad.oe <= 18'h00000;
         pad.pu_en <= 18'h3FFFF;
      end else begin
         for (int i = 0; i < KPI_NL; i++) begin
            if (in_kp_q[i] && i >= KPI_NROW) begin
               pad.o[i] <= 1'b0; // open-drain, pulls low only
               pad.oe[i] <= ~out_val_q[i];
               pad.pu_en[i] <= 1'b0;
            end else if (in_kp_q[i]) begin
               pad.o[i] <= 1'b0; // sense input with pull-up
               pad.oe[i] <= 1'b0;
               pad.pu_en[i] <= 1'b1;
            end else begin
               pad.o[i] <= out_val_q[i]; // push-pull gpio
               pad.oe[i] <= is_out_q[i];
               pad.pu_en[i] <= ~is_out_q[i];
            end
         end
      end
   end

   // debounced level crosses in as a level, two flops
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         lx_m_q <= KPI_LVL_RST;
         lvl_q <= KPI_LVL_RST;
         lvl_p_q <= KPI_LVL_RST;
      end else begin
         lx_m_q <= db_b_q;
         lvl_q <= lx_m_q;
         lvl_p_q <= lvl_q;
      end
   end

   assign edge_v = (lvl_q ^ lvl_p_q) & in_mask;

   // pending bits: edge sets, return-to-reference or read clears
   always_comb begin
      ist_d = ist_q;
      for (int i = 0; i < KPI_NL; i++) begin
         if (lvl_q[i] == ref_q[i]) begin
            ist_d[i] = 1'b0;
         end
         if (clr_stb && rd_mask[i]) begin
            ist_d[i] = 1'b0;
         end
         if (!in_mask[i]) begin
            ist_d[i] = 1'b0;
         end
         if (edge_v[i]) begin
            ist_d[i] = 1'b1; // set wins over clear
         end
      end
   end

   // reference is retaken at a read clear; a later output-to-input
   // switch against a stale reference can flag once, by design
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ist_q <= 18'h00000;
         ref_q <= KPI_LVL_RST;
      end else begin
         ist_q <= ist_d;
         if (clr_stb) begin
            ref_q <= (ref_q & ~rd_mask) | (lvl_q & rd_mask);
         end
      end
   end

   // clear attempt with work still pending: gap or hold
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pls_q <= 10'h000;
      end else if (clr_stb && (|rd_mask) && int_q && (|ist_d) && cfg_q[KPI_CFG_INTP]) begin
         pls_q <= 10'(KPI_PULSE_CYC);
      end else if (pls_q != 10'h000) begin
         pls_q <= pls_q - 10'h001;
      end
   end

   // interrupt: pin pulled low while pending and no gap running
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         int_q <= 1'b0;
      end else begin
         int_q <= (|ist_d) && (pls_q == 10'h000);
      end
   end

   assign int_n_o = 1'b0;   // open-drain, never drives high
   assign int_n_oe = int_q;

   // bus lines: two flops to synchronise, third for history
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
      end else begin
         scl_s_q <= {scl_s_q[1:0], scl_i};
         sda_s_q <= {sda_s_q[1:0], sda_i};
      end
   end

   // conditions judged only on synchronised stages
   assign scl_rise = scl_s_q[1] && !scl_s_q[2];
   assign scl_fall = !scl_s_q[1] && scl_s_q[2];
   assign bus_start = scl_s_q[1] && scl_s_q[2] && !sda_s_q[1] && sda_s_q[2];
   assign bus_stop = scl_s_q[1] && scl_s_q[2] && sda_s_q[1] && !sda_s_q[2];
   assign clr_stb = (st_q == KPI_RACK) && scl_rise;
   assign nxt_ptr = cfg_q[KPI_CFG_AI] ? ptr_q + 8'h01 : ptr_q;
   // only a status or level port read counts as a clear attempt
   assign rd_mask = port_mask(rda_q);
   assign rd_byte = rd_data(ptr_q, cfg_q, ist_q, lvl_q);

   // bus slave; data only changes after the clock falls
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_q <= KPI_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         ptr_q <= 8'h00;
         rda_q <= 8'h00;
         ptr_ok_q <= 1'b0;
         sda_oe_q <= 1'b0;
         cfg_q <= KPI_CFG_RST;
      end else if (bus_start) begin
         st_q <= KPI_ADDR;
         cnt_q <= 4'h0;
         sda_oe_q <= 1'b0;
      end else if (bus_stop) begin
         st_q <= KPI_IDLE;
         sda_oe_q <= 1'b0;
      end else begin
         case (st_q)
            KPI_IDLE, KPI_WAIT: begin
               sda_oe_q <= 1'b0; // foreign traffic ignored
            end
            KPI_ADDR: begin
               if (scl_rise) begin
                  sh_q <= {sh_q[6:0], sda_s_q[1]}; // msb first
                  cnt_q <= cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == 4'h8) begin
                  if (sh_q[7:1] == KPI_SLV_ADDR) begin
                     st_q <= KPI_AACK;
                     sda_oe_q <= 1'b1;
                  end else begin
                     st_q <= KPI_WAIT;
                  end
               end
            end
            KPI_AACK: begin
               if (scl_fall) begin
                  cnt_q <= 4'h0;
                  ptr_ok_q <= 1'b0;
                  if (sh_q[0]) begin
                     st_q <= KPI_RBYTE; // read
                     tx_q <= rd_byte;
                     rda_q <= ptr_q;
                     sda_oe_q <= ~rd_byte[7];
                  end else begin
                     st_q <= KPI_WBYTE; // write
                     sda_oe_q <= 1'b0;
                  end
               end
            end
            KPI_WBYTE: begin
               if (scl_rise) begin
                  sh_q <= {sh_q[6:0], sda_s_q[1]};
                  cnt_q <= cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == 4'h8) begin
                  st_q <= KPI_WACK;
                  sda_oe_q <= 1'b1;
                  ptr_ok_q <= 1'b1;
                  if (!ptr_ok_q) begin
                     ptr_q <= sh_q;
                  end else begin
                     if (ptr_q == KPI_A_CFG) begin
                        cfg_q <= sh_q;
                     end
                     ptr_q <= nxt_ptr;
                  end
               end
            end
            KPI_WACK: begin
               if (scl_fall) begin
                  st_q <= KPI_WBYTE;
                  cnt_q <= 4'h0;
                  sda_oe_q <= 1'b0;
               end
            end
            KPI_RBYTE: begin
               if (scl_rise) begin
                  cnt_q <= cnt_q + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_q == 4'h8) begin
                     st_q <= KPI_RACK;
                     sda_oe_q <= 1'b0; // master acknowledges
                     ptr_q <= nxt_ptr;
                  end else begin
                     tx_q <= {tx_q[6:0], 1'b0};
                     sda_oe_q <= ~tx_q[6];
                  end
               end
            end
            KPI_RACK: begin
               if (scl_rise) begin
                  if (sda_s_q[1]) begin
                     st_q <= KPI_WAIT; // nack, stay released
                  end else begin
                     cnt_q <= 4'h0;
                  end
               end else if (scl_fall) begin
                  st_q <= KPI_RBYTE;
                  cnt_q <= 4'h0;
                  tx_q <= rd_byte;
                  rda_q <= ptr_q;
                  sda_oe_q <= ~rd_byte[7];
               end
            end
            default: begin
               st_q <= KPI_IDLE;
               sda_oe_q <= 1'b0;
            end
         endcase
      end
   end

   assign sda_o = 1'b0; // open-drain: only pulls low
   assign sda_oe = sda_oe_q;
endmodule : kpi_host_port

// ===== kpi_host_port_props.sv
`timescale 1ns/100ps
module kpi_host_port_chk (
   // clocks and reset
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic dbclk,
   // bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   // lines and pads
   input wire logic [17:0] line_i,
   input wire kpi_pkg::kpi_line_cfg_s line_cfg,
   input wire kpi_pkg::kpi_pad_s pad,
   // interrupt pin
   input wire logic int_n_o,
   input wire logic int_n_oe
);
   import kpi_pkg::*;
   // every check here lives in the main clock domain
   default clocking cb @(posedge mclk);
   endclocking
   // data drive held for two cycles, the synchroniser delay
   sequence oe_quiet2;
      $stable(sda_oe) [*2];
   endsequence
   rst_idle_a: assert property (
      !rst_n |=> !int_n_oe && !sda_oe && pad.oe == '0 && pad.pu_en == '1)
      else $error("outputs not idle in reset");
   pull_ups_a: assert property (
      disable iff (!rst_n) $rose(rst_n) |-> pad.pu_en == '1 && pad.oe == '0)
      else $error("lines not pulled inputs after reset");
   int_od_a: assert property (disable iff (!rst_n) !int_n_o)
      else $error("interrupt pin driven high");
   sda_od_a: assert property (disable iff (!rst_n) sda_oe |-> !sda_o)
      else $error("data pin driven high");
   // keypad sense lines are never driven and keep their pull-up
   sense_pad_a: assert property (
      disable iff (!rst_n) $past(rst_n, 2) |-> (pad.oe[7:0] & $past(line_cfg.in_kp[7:0], 2)) == 8'h00
         && (pad.pu_en[7:0] | ~$past(line_cfg.in_kp[7:0], 2)) == 8'hFF)
      else $error("keypad sense pad wrong");
   // keypad drive lines enable their pad driver exactly when out_val is low
   drive_pad_a: assert property (
      disable iff (!rst_n) $past(rst_n, 2) |->
         ((pad.oe[17:8] ^ ~$past(line_cfg.out_val[17:8], 2)) & $past(line_cfg.in_kp[17:8], 2)) == 10'h000)
      else $error("keypad drive pad wrong");
   sda_move_a: assert property (
      disable iff (!rst_n) $changed(sda_oe) |-> !scl_i && !$past(scl_i))
      else $error("data moved while clock high");
   scl_sync_a: assert property (
      disable iff (!rst_n) $fell(scl_i) |-> ##1 oe_quiet2)
      else $error("data moved before clock synchronised");
endmodule : kpi_host_port_chk
bind kpi_host_port kpi_host_port_chk chk_i (.mclk(mclk), .rst_n(rst_n), .dbclk(dbclk), .scl_i(scl_i),
   .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .line_i(line_i), .line_cfg(line_cfg), .pad(pad),
   .int_n_o(int_n_o), .int_n_oe(int_n_oe));

// ===== kpi_bus_master.sv
`timescale 1ns/100ps
module kpi_bus_master (
   // pacing clock
   input wire logic mclk,
   // wired data level
   input wire logic sda,
   // driven bus lines
   output logic scl,
   output logic sda_m
);
   // bus idles released and high
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // one phase, far above the four cycle minimum
   task automatic hp;
      repeat (10) @(posedge mclk);
      #1;
   endtask : hp
   // clock dropped first so a held ack is let go first
   task automatic start;
      scl = 1'b0;
      hp();
      sda_m = 1'b1;
      hp();
      scl = 1'b1;
      hp();
      sda_m = 1'b0;
      hp();
   endtask : start
   // data rises while clock high
   task automatic stop;
      scl = 1'b0;
      hp();
      sda_m = 1'b0;
      hp();
      scl = 1'b1;
      hp();
      sda_m = 1'b1;
      hp();
   endtask : stop
   // data moves only a phase after clock low
   task automatic clk(input logic b, output logic s);
      scl = 1'b0;
      hp();
      sda_m = b;
      hp();
      scl = 1'b1;
      hp();
      s = sda;
   endtask : clk
   // msb first, released for the ack
   task automatic wr(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         clk(d[i], s);
      clk(1'b1, s);
      ack = ~s;
   endtask : wr
   // ack all but the last, which is left high
   task automatic rd(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk(1'b1, s);
         d[i] = s;
      end
      clk(last, s);
   endtask : rd
endmodule : kpi_bus_master

// ===== kpi_host_port_tb.sv
`timescale 1ns/100ps
module kpi_host_port_tb;
   import kpi_pkg::*;
   // stimulus and observed pins
   logic mclk;
   logic dbclk;
   logic rst_n;
   logic scl;
   logic sda_m;
   logic sda_o;
   logic sda_oe;
   logic [17:0] line_i;
   kpi_line_cfg_s line_cfg;
   kpi_pad_s pad;
   logic int_n_o;
   logic int_n_oe;
   int num_errors;
   int tests_run;
   int cyc = 0;
   int idx;
   logic [7:0] rb;
   // pulled-up data line, low when either side pulls
   wire sda = sda_m & ~(sda_oe & ~sda_o);
   kpi_host_port dut (.mclk(mclk), .rst_n(rst_n), .dbclk(dbclk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .line_i(line_i), .line_cfg(line_cfg), .pad(pad), .int_n_o(int_n_o), .int_n_oe(int_n_oe));
   kpi_bus_master m (.mclk(mclk), .sda(sda), .scl(scl), .sda_m(sda_m));
   // main clock
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // debounce clock, offset so its phase drifts
   initial begin
      dbclk = 1'b0;
      #17;
      forever #62.5 dbclk = ~dbclk;
   end
   // hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         num_errors++;
         summarize();
      end
   end
   task automatic chk(input string nm, input logic [17:0] got, input logic [17:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   task automatic cyc_w(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc_w
   task automatic ichk(input logic exp);
      chk("int", {17'h0, int_n_oe}, {17'h0, exp});
   endtask : ichk
   // move a line, wait out the debounce, then look at the interrupt
   task automatic edge_chk(input int i, input logic v, input logic exp);
      line_i[i] = v;
      cyc_w(40);
      ichk(exp);
   endtask : edge_chk
   task automatic send(input logic [7:0] b, input logic exp);
      logic a;
      m.wr(b, a);
      chk("ack", {17'h0, a}, {17'h0, exp});
   endtask : send
   task automatic rd_reg(input logic [7:0] p, input logic [7:0] exp);
      logic [7:0] d;
      m.start();
      send({KPI_SLV_ADDR, 1'b0}, 1'b1);
      send(p, 1'b1);
      m.start();
      send({KPI_SLV_ADDR, 1'b1}, 1'b1);
      m.rd(1'b1, d);
      m.stop();
      chk("rdata", {10'h0, d}, {10'h0, exp});
      cyc_w(20);
   endtask : rd_reg
   // expected status port and bit of a line
   function automatic logic [7:0] port_of(input int i);
      return KPI_A_IST1 + 8'(i / 8);
   endfunction : port_of
   function automatic logic [7:0] bit_of(input int i);
      return 8'h01 << (i % 8);
   endfunction : bit_of
   initial begin
      rst_n = 1'b0;
      line_i = KPI_LVL_RST;
      line_cfg = '0;
      num_errors = 0;
      tests_run = 0;
      void'($urandom(32'hBB63AB0B));
      cyc_w(12);
      rst_n = 1'b1;
      cyc_w(1);
      chk("pu", pad.pu_en, 18'h3FFFF);
      chk("oe", pad.oe, 18'h00000);
      $display("test reset done");
      line_cfg.in_kp = '1;
      line_cfg.out_val = 18'($urandom);
      cyc_w(3);
      chk("kp_oe", pad.oe, {~line_cfg.out_val[17:8], 8'h00});
      chk("kp_pu", pad.pu_en, 18'h000FF);
      chk("kp_o", pad.o, 18'h00000);
      line_cfg = '0;
      cyc_w(40);
      ichk(1'b0);
      $display("test keypad done");
      // a 100 ns pulse is caught by one debounce sample at most
      line_i[2] = 1'b0;
      cyc_w(1);
      edge_chk(2, 1'b1, 1'b0);
      repeat (3) begin
         idx = $urandom_range(17, 0);
         edge_chk(idx, 1'b0, 1'b1);
         edge_chk(idx, 1'b1, 1'b0);
         edge_chk(idx, 1'b0, 1'b1);
         rd_reg(port_of(idx), bit_of(idx));
         ichk(1'b0);
         edge_chk(idx, 1'b1, 1'b1);
         rd_reg(port_of(idx), bit_of(idx));
      end
      $display("test edges done");
      line_cfg.is_out[5] = 1'b1;
      line_cfg.out_val[5] = 1'b1;
      edge_chk(5, 1'b0, 1'b0);
      chk("gp_o", pad.o, 18'h00020);
      chk("gp_oe", pad.oe, 18'h00020);
      chk("gp_pu", pad.pu_en, 18'h3FFDF);
      edge_chk(5, 1'b1, 1'b0);
      line_cfg = '0;
      edge_chk(0, 1'b0, 1'b1);
      edge_chk(9, 1'b0, 1'b1);
      m.start();
      send({7'h35, 1'b1}, 1'b0);
      m.stop();
      ichk(1'b1);
      rd_reg(KPI_A_IST1, 8'h01);
      ichk(1'b1);
      $display("test hold done");
      m.start();
      send({KPI_SLV_ADDR, 1'b0}, 1'b1);
      send(KPI_A_CFG, 1'b1);
      send(8'h90, 1'b1);
      m.stop();
      rd_reg(KPI_A_CFG, 8'h90);
      ichk(1'b1);
      edge_chk(0, 1'b1, 1'b1);
      rd_reg(KPI_A_IST1, 8'h01);
      ichk(1'b0);
      cyc_w(KPI_PULSE_CYC);
      ichk(1'b1);
      rd_reg(KPI_A_IST2, 8'h02);
      ichk(1'b0);
      // two bytes in one read: pointer steps, master acks the first
      m.start();
      send({KPI_SLV_ADDR, 1'b0}, 1'b1);
      send(KPI_A_DAT1, 1'b1);
      m.start();
      send({KPI_SLV_ADDR, 1'b1}, 1'b1);
      m.rd(1'b0, rb);
      chk("dat1", {10'h0, rb}, 18'h000FF);
      m.rd(1'b1, rb);
      m.stop();
      chk("dat2", {10'h0, rb}, 18'h000FD);
      $display("test pulse done");
      // reset in mid-run with a pending change; lines idle during it
      edge_chk(3, 1'b0, 1'b1);
      rst_n = 1'b0;
      line_i = KPI_LVL_RST;
      cyc_w(12);
      ichk(1'b0);
      rst_n = 1'b1;
      cyc_w(40);
      ichk(1'b0);
      rd_reg(KPI_A_CFG, KPI_CFG_RST);
      $display("test reset again done");
      summarize();
   end
endmodule : kpi_host_port_tb
